// File: acc_params.svh
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
// register byte addresses
`define ACC_OFF_CTRL1    12'h000
`define ACC_OFF_CTRL2    12'h004
`define ACC_OFF_STATUS   12'h008
`define ACC_OFF_IRQ_STAT 12'h00C
`define ACC_OFF_IRQ_MASK 12'h010
// control register fields
`define ACC_B_ON      15
`define ACC_B_OE      14
`define ACC_B_INV     13
`define ACC_B_LPWR    12
`define ACC_B_EVT     9
`define ACC_B_RES     8
`define ACC_B_EVENT_POLARITY_H 7
`define ACC_B_EVENT_POLARITY_L 6
`define ACC_B_REF     4
`define ACC_B_CCH_H   1
`define ACC_B_CCH_L   0
// writable bits of control and status
`define ACC_CTRL_WMASK 16'hF2D3
`define ACC_STAT_WMASK 16'h8000
// status fields
`define ACC_B_IDLE 15
`define ACC_B_EVM  8
`define ACC_B_RESM 0
// reset values
`define ACC_CTRL_RST 16'h0000
`define ACC_STAT_RST 16'h0000
`endif

// File: acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_EV_OFF  = 2'b00,
    ACC_EV_RISE = 2'b01,
    ACC_EV_FALL = 2'b10,
    ACC_EV_ANY  = 2'b11
  } acc_event_polarity_type;
  typedef enum logic [1:0] {
    ACC_CH_B  = 2'b00,
    ACC_CH_C  = 2'b01,
    ACC_CH_D  = 2'b10,
    ACC_CH_BG = 2'b11
  } acc_chan_type;
endpackage

// File: acc_if.sv
`timescale 1ns/1ns
// control and event signals between top and one comparator channel
interface acc_if;
  logic [15:0] ctrl;      // control register contents
  logic        run;       // comparator active
  logic        raw_cmp;   // raw analog result as logic
  logic        result;    // synchronised, polarity-applied result
  logic        ev_set;    // one-cycle event pulse
  modport top (output ctrl, output run, output raw_cmp, input result, input ev_set);
  modport chan (input ctrl, input run, input raw_cmp, output result, output ev_set);
endinterface

// File: acc_chan.sv
`timescale 1ns/1ns
`include "acc_params.svh"
// one comparator: sync, polarity, edge-qualified event detection
module acc_chan
(
  input  wire logic pclk,
  input  wire logic presetn,
  acc_if.chan       cif
);
  logic       s1_q;
  logic       s2_q;
  logic       prev_q;
  logic       first_q;
  logic [1:0] pol_q;
  logic       pol_res;
  logic       rise;
  logic       fall;
  logic       fire;
  logic       armed;
  acc_pkg::acc_event_polarity_type pol;

  // ----------------------------------------
  // polarity and edge decode
  // ----------------------------------------
  assign pol     = acc_pkg::acc_event_polarity_type'(cif.ctrl[`ACC_B_EVENT_POLARITY_H:`ACC_B_EVENT_POLARITY_L]);
  assign pol_res = cif.run & (s2_q ^ cif.ctrl[`ACC_B_INV]);
  assign rise    = pol_res & ~prev_q;
  assign fall    = ~pol_res & prev_q;
  // first event after arming takes any edge, then the chosen polarity
  // armed already in the cycle the code leaves off, before first_q catches up
  assign armed   = first_q | (pol_q == 2'b00);
  assign fire    = ~cif.ctrl[`ACC_B_EVT] & (pol != acc_pkg::ACC_EV_OFF) &
                   ((armed | pol == acc_pkg::ACC_EV_ANY) ? (rise | fall) :
                    (pol == acc_pkg::ACC_EV_RISE) ? rise :
                    (pol == acc_pkg::ACC_EV_FALL) ? fall : 1'b0);
  assign cif.result = prev_q;
  assign cif.ev_set = fire;

  // ----------------------------------------
  // two-stage sync of the raw result
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= cif.raw_cmp;
      s2_q <= s1_q;
    end
  end

  // edge history and first-event arming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q  <= 1'b0;
      pol_q   <= 2'b00;
      first_q <= 1'b0;
    end
    else
    begin
      prev_q <= pol_res;
      pol_q  <= pol;
      if (fire)
        first_q <= 1'b0;
      else if (pol_q == 2'b00 && pol != acc_pkg::ACC_EV_OFF)
        first_q <= 1'b1;               // re-armed by leaving the off code
    end
  end
endmodule // acc_chan

// File: acc_top.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "acc_params.svh"
// Notes on behaviour
// - one or two comparators, shared status register
// - enable bit 15 turns comparator on
// - output enable drives the unsynchronised, polarity-applied result to pad
// - polarity bit inverts the read result
// - low-power bit selects low-power analog mode
// - event polarity: any, fall, rise, off
// - event flag set, blocks further events
// - first event after arming takes any edge
// - reference bit picks internal reference or pin A
// - channel select picks B, C, D, half bandgap
// - stop-in-idle halts all comparators in idle
// - status bits 9,8 mirror event flags
// - status bits 1,0 mirror result bits
// - unimplemented bits ignore writes, read zero
module acc_top
#(
  parameter int NUM_CMP = 2
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                idle_mode,
  input  wire logic [NUM_CMP-1:0]  analog_result,
  output logic      [NUM_CMP-1:0]  cmp_on,
  output logic      [NUM_CMP-1:0]  low_power_select,
  output logic      [NUM_CMP-1:0]  noninv_ref_select,
  output logic      [2*NUM_CMP-1:0] inverting_channel_select,
  output logic      [NUM_CMP-1:0]  result_pad,
  output logic      [NUM_CMP-1:0]  result_pad_oe,
  output logic      [NUM_CMP-1:0]  cmp_irq_pulse,
  output logic                     irq
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [15:0]        ctrl_q [NUM_CMP];
  logic               idle_stop_q;
  logic [NUM_CMP-1:0] evt_q;
  logic [NUM_CMP-1:0] ist_q;
  logic [NUM_CMP-1:0] imask_q;
  logic [31:0]        prdata_q;
  logic [NUM_CMP-1:0] ev_set;
  logic [NUM_CMP-1:0] res;
  logic [NUM_CMP-1:0] run;
  logic [15:0]        ctrl_rd [NUM_CMP];
  logic [15:0]        stat_rd;
  logic               wr_en;
  logic               rd_en;
  logic               hit_stat;
  logic               hit_ist;
  logic               hit_imask;
  logic [NUM_CMP-1:0] hit_ctrl;
  logic               hit_any;
  logic [31:0]        rd_mux;

  // ----------------------------------------
  // apb decode, zero-wait answer
  // ----------------------------------------
  function automatic logic [11:0] ctrl_addr(input int idx);
    ctrl_addr = (idx == 0) ? `ACC_OFF_CTRL1 : `ACC_OFF_CTRL2;
  endfunction

  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & ~penable & ~pwrite;
  assign hit_stat  = (paddr == `ACC_OFF_STATUS);
  assign hit_ist   = (paddr == `ACC_OFF_IRQ_STAT);
  assign hit_imask = (paddr == `ACC_OFF_IRQ_MASK);
  assign hit_any   = hit_stat | hit_ist | hit_imask | (|hit_ctrl);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit_any;
  assign prdata    = prdata_q;

  // ----------------------------------------
  // per-comparator channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++)
    begin : g_cmp
      acc_if cif ();
      assign hit_ctrl[g] = (paddr == ctrl_addr(g));
      // idle halts every comparator when stop-in-idle is set
      assign run[g] = ctrl_q[g][`ACC_B_ON] & ~(idle_stop_q & idle_mode);
      assign cif.ctrl    = ctrl_rd[g];
      assign cif.run     = run[g];
      assign cif.raw_cmp = analog_result[g];
      assign res[g]      = cif.result;
      assign ev_set[g]   = cif.ev_set;
      // readback: unimplemented bits zero, live event and result
      assign ctrl_rd[g] = (ctrl_q[g] & `ACC_CTRL_WMASK & ~(16'h0001 << `ACC_B_EVT))
                          | ({15'h0000, evt_q[g]} << `ACC_B_EVT)
                          | ({15'h0000, res[g]} << `ACC_B_RES);
      // analog controls
      assign cmp_on[g]            = run[g];
      assign low_power_select[g]  = ctrl_q[g][`ACC_B_LPWR];
      assign noninv_ref_select[g] = ctrl_q[g][`ACC_B_REF];
      assign inverting_channel_select[2*g+1:2*g] =
        ctrl_q[g][`ACC_B_CCH_H:`ACC_B_CCH_L];
      // unsynchronised result straight to the pad
      assign result_pad[g]    = run[g] & (analog_result[g] ^ ctrl_q[g][`ACC_B_INV]);
      assign result_pad_oe[g] = ctrl_q[g][`ACC_B_OE];
      assign cmp_irq_pulse[g] = ev_set[g];

      acc_chan u_chan
      (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif)
      );

      // control register write; event flag set beats software clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ctrl_q[g] <= `ACC_CTRL_RST;
          evt_q[g]  <= 1'b0;
        end
        else
        begin
          if (wr_en && hit_ctrl[g])
            ctrl_q[g] <= pwdata[15:0] & `ACC_CTRL_WMASK;
          if (ev_set[g])
            evt_q[g] <= 1'b1;
          else if (wr_en && hit_ctrl[g])
            evt_q[g] <= pwdata[`ACC_B_EVT];
        end
      end

      // sticky interrupt status, write one to clear, set wins
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ist_q[g]   <= 1'b0;
          imask_q[g] <= 1'b0;
        end
        else
        begin
          if (ev_set[g])
            ist_q[g] <= 1'b1;
          else if (wr_en && hit_ist && pwdata[g])
            ist_q[g] <= 1'b0;
          if (wr_en && hit_imask)
            imask_q[g] <= pwdata[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // status register image
  // ----------------------------------------
  assign stat_rd = ({15'h0000, idle_stop_q} << `ACC_B_IDLE)
                 | (16'(evt_q) << `ACC_B_EVM)
                 | (16'(res) << `ACC_B_RESM);

  // read mux over all decoded registers
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_CMP; i++)
      if (hit_ctrl[i])
        rd_mux = {16'h0000, ctrl_rd[i]};
    if (hit_stat)
      rd_mux = {16'h0000, stat_rd};
    if (hit_ist)
      rd_mux = 32'(ist_q);
    if (hit_imask)
      rd_mux = 32'(imask_q);
  end

  // stop-in-idle bit and registered read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_stop_q <= 1'b0;
      prdata_q    <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && hit_stat)
        idle_stop_q <= pwdata[`ACC_B_IDLE];
      if (rd_en)
        prdata_q <= rd_mux;
    end
  end

  assign irq = |(ist_q & imask_q);
endmodule // acc_top

// File: acc_top_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checker for the comparator block
// ----------------------------------------
module acc_top_chk
#(
  parameter int NUM_CMP = 2
)
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               idle_mode,
  input wire logic [NUM_CMP-1:0] cmp_on,
  input wire logic [NUM_CMP-1:0] result_pad,
  input wire logic [NUM_CMP-1:0] cmp_irq_pulse,
  input wire logic               irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access phase
  wire wr_acc = psel && penable && pwrite;
  unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("pslverr missing on unmapped access");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("pslverr on mapped access");
  ready_high_a: assert property (pready)
    else $error("pready low");
  pad_off_a: assert property ((result_pad & ~cmp_on) == '0)
    else $error("pad driven while comparator off");
  pulse_once_a: assert property (cmp_irq_pulse[0] |=> !cmp_irq_pulse[0] [*2])
    else $error("event pulse repeated");
  irq_rise_a: assert property ($rose(irq) |-> $past(|cmp_irq_pulse) || $past(wr_acc))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc))
    else $error("irq fell without write");
  on_rise_a: assert property ($rose(cmp_on[0]) |-> $past(wr_acc) || $fell(idle_mode))
    else $error("comparator started without cause");
  cover property (cmp_irq_pulse[0]);
  cover property ($fell(irq));
  cover property (pslverr);
endmodule // acc_top_chk

// File: test_acc_top.sv
`timescale 1ns/1ns
`include "acc_params.svh"
// ----------------------------------------
// bench for the comparator block
// ----------------------------------------
module test_acc_top;
  logic        pclk, presetn, psel, penable, pwrite, idle_mode, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exp_q[$];
  logic [1:0]  analog_result, cmp_on, low_power_select, noninv_ref_select;
  logic [1:0]  result_pad, result_pad_oe, cmp_irq_pulse;
  logic [3:0]  inverting_channel_select;
  int          error_cnt = 0, samples_checked = 0, npulse = 0;
  acc_top #(.NUM_CMP(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .analog_result(analog_result),
    .cmp_on(cmp_on), .low_power_select(low_power_select), .noninv_ref_select(noninv_ref_select),
    .inverting_channel_select(inverting_channel_select), .result_pad(result_pad),
    .result_pad_oe(result_pad_oe), .cmp_irq_pulse(cmp_irq_pulse), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer: setup, then access until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  // read data compared against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("prdata", prdata, exp_q.pop_front());
  always @(posedge pclk)
    if (cmp_irq_pulse[0] === 1'b1)
      npulse++;
  initial
  begin
    logic [31:0] d;
    {psel, penable, pwrite, idle_mode, presetn} = '0;
    {paddr, pwdata, analog_result} = '0;
    void'($urandom(86942));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0000_0000);
    xfer(1'b1, `ACC_OFF_CTRL1, 32'hFFFF_FC3F);
    repeat (4) @(posedge pclk);
    rd(`ACC_OFF_CTRL1, 32'h0000_F113);
    rd(`ACC_OFF_STATUS, 32'h0000_0001);
    @(negedge pclk);
    chk("pins1", {cmp_on[0], low_power_select[0], noninv_ref_select[0],
      inverting_channel_select[1:0], result_pad_oe[0], result_pad[0]}, 32'h0000_007F);
    for (int c = 0; c < 4; c++)
    begin
      d = 32'h0000_8000 | c | ($urandom & 32'h0000_5010);
      xfer(1'b1, `ACC_OFF_CTRL2, d);
      @(negedge pclk);
      chk("pins2", {cmp_on[1], low_power_select[1], noninv_ref_select[1],
        inverting_channel_select[3:2], result_pad_oe[1]},
        {1'b1, d[12], d[4], d[1:0], d[14]});
    end
    chk("no_event", npulse, 0);
    xfer(1'b1, `ACC_OFF_STATUS, 32'h0000_8000);
    @(posedge pclk) idle_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`ACC_OFF_STATUS, 32'h0000_8000);
    @(negedge pclk) chk("on_idle", cmp_on, 0);
    @(posedge pclk) idle_mode <= 1'b0;
    @(posedge pclk) analog_result[0] <= 1'b1;
    xfer(1'b1, `ACC_OFF_CTRL1, 32'h0000_8000);
    xfer(1'b1, `ACC_OFF_IRQ_MASK, 32'h0000_0001);
    xfer(1'b1, `ACC_OFF_CTRL1, 32'h0000_8040);
    @(posedge pclk) analog_result[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(`ACC_OFF_CTRL1, 32'h0000_8240);
    rd(`ACC_OFF_STATUS, 32'h0000_8100);
    @(posedge pclk) analog_result[0] <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("irq_set", irq, 1);
    chk("blocked", npulse, 1);
    xfer(1'b1, `ACC_OFF_CTRL1, 32'h0000_8040);
    @(posedge pclk) analog_result[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("no_fall", npulse, 1);
    analog_result[0] <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("rise_only", npulse, 2);
    xfer(1'b1, `ACC_OFF_STATUS, 32'hFFFF_FFFF);
    rd(`ACC_OFF_STATUS, 32'h0000_8101);
    xfer(1'b1, `ACC_OFF_IRQ_STAT, 32'h0000_0001);
    @(negedge pclk) chk("irq_clr", irq, 0);
    xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
    rd(12'h020, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    give_verdict;
  end
  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    give_verdict;
  end
endmodule // test_acc_top
bind acc_top acc_top_chk #(.NUM_CMP(NUM_CMP)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .idle_mode(idle_mode), .cmp_on(cmp_on), .result_pad(result_pad),
  .cmp_irq_pulse(cmp_irq_pulse), .irq(irq));
